// File: rtl/csfr_map.svh
// Register map, field positions and reset values of the status register.
// Assumes inclusion by bare name from the package only; the design files use its macros through it.
`ifndef CSFR_MAP_SVH
`define CSFR_MAP_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define CSFR_IDX_BANK0 9'h003
`define CSFR_IDX_BANK1 9'h083
`define CSFR_IDX_BANK2 9'h103
`define CSFR_IDX_BANK3 9'h183
`define CSFR_IDX_LOW_MSB 6
`define CSFR_IDX_LOW 7'h03
`define CSFR_IDX_TOP_W 23

// ****************************************
// Field positions
// ****************************************
`define CSFR_BIT_IRP 7
`define CSFR_BIT_RPH 6
`define CSFR_BIT_RPL 5
`define CSFR_BIT_TO 4
`define CSFR_BIT_PD 3
`define CSFR_BIT_Z 2
`define CSFR_BIT_DC 1
`define CSFR_BIT_C 0

// ****************************************
// Values
// ****************************************
`define CSFR_RESET 8'h18
`define CSFR_NIBBLE_MSB 4
`define CSFR_BYTE_MSB 8
`define CSFR_HTRANS_NONSEQ 2'h2
`define CSFR_HRESP_OKAY 1'h0

`endif

// File: rtl/csfr_pkg.sv
// Types shared by the status register and its flag unit.
// Assumes csfr_map.svh sits beside it.
package csfr_pkg;
   `include "csfr_map.svh"

   typedef enum logic [2:0] {
      CSFR_ALU_NONE = 3'b000,
      CSFR_ALU_ADD = 3'b001,
      CSFR_ALU_SUB = 3'b010,
      CSFR_ALU_LOGIC = 3'b011,
      CSFR_ALU_CLEAR = 3'b100
   } csfr_alu_op_t;

   typedef struct packed {
      logic [7:0] status;
      logic wr_pend;
      logic [7:0] rd_data;
   } csfr_state_t;
endpackage : csfr_pkg

// File: rtl/csfr_flag_unit.sv
// Flag unit: zero, digit carry and carry of one ALU operation.
// Assumes operands and the logic result are stable in the cycle of the op.
`timescale 1ns/1ps
module csfr_flag_unit
   import csfr_pkg::*;
(
   input wire csfr_alu_op_t op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic [7:0] logic_res_i,
   output logic z_o,
   output logic dc_o,
   output logic c_o
);
   logic [7:0] opnd;
   logic [8:0] sum;
   logic [4:0] nib;

   always_comb begin
      // Subtraction adds the two's complement, so C and DC read as not-borrow
      opnd = (op_i == CSFR_ALU_SUB) ? ~b_i : b_i;
      sum = {1'b0, a_i} + {1'b0, opnd}
         + {8'h00, (op_i == CSFR_ALU_SUB)};
      nib = {1'b0, a_i[3:0]} + {1'b0, opnd[3:0]}
         + {4'h0, (op_i == CSFR_ALU_SUB)};
      c_o = sum[`CSFR_BYTE_MSB];
      dc_o = nib[`CSFR_NIBBLE_MSB];
      unique case (op_i)
         CSFR_ALU_ADD, CSFR_ALU_SUB: z_o = (sum[7:0] == 8'h00);
         CSFR_ALU_LOGIC: z_o = (logic_res_i == 8'h00);
         CSFR_ALU_CLEAR: z_o = 1'b1;
         CSFR_ALU_NONE: z_o = 1'b0;
         default: z_o = 1'b0;
      endcase
   end
endmodule : csfr_flag_unit

// File: rtl/csfr_status.sv
// Processor status register with core update port and AHB-Lite slave.
// Assumes one clock, synchronous reset at power-up, decoder pulses per op.
//
// What this block does
// - Holds ALU flags, reset-cause flags and bank-select bits in one register.
// - Status register accepts instruction results like any data register.
// - Flag-affecting ops drop written Z, DC, C and use their own flags.
// - Instruction writes never change watchdog-expiry or sleep-entered flags.
// - Clear op takes bank bits from write data, sets zero, keeps reset and carry flags.
// - On subtraction carry and digit carry mean not-borrow.
// - Same register reached at the status offset of all four banks.
// - Watchdog flag cleared by timeout, set by power-up, kick or sleep.
// - Sleep flag set by power-up or kick, cleared by sleep.
// - Zero flag follows whether the result is zero.
// - Carry from result top bit, digit carry from bit four.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module csfr_status
   import csfr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Core side
   input wire logic core_wr_i,
   input wire logic [8:0] core_addr_i,
   input wire logic [7:0] core_wr_data_i,
   input wire csfr_alu_op_t alu_op_i,
   input wire logic [7:0] alu_a_i,
   input wire logic [7:0] alu_b_i,
   input wire logic [7:0] logic_res_i,
   input wire logic wdt_timeout_i,
   input wire logic watchdog_kick_i,
   input wire logic sleep_i,
   output logic [7:0] processor_flags_o,
   output logic indirect_bank_select_o,
   output logic [1:0] direct_bank_field_o,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o
);
   csfr_state_t r;
   csfr_state_t next_r;
   logic fu_z;
   logic fu_dc;
   logic fu_c;
   logic core_hit;
   logic bus_hit;
   logic bus_take;
   logic [7:0] wdat;
   logic wr_any;

   // ****************************************
   // Flag unit
   // ****************************************
   csfr_flag_unit u_flags (
      .op_i(alu_op_i),
      .a_i(alu_a_i),
      .b_i(alu_b_i),
      .logic_res_i(logic_res_i),
      .z_o(fu_z),
      .dc_o(fu_dc),
      .c_o(fu_c)
   );

   // ****************************************
   // Address decode
   // ****************************************
   always_comb begin
      // Bank bits of the address are ignored, so all four mirrors hit
      core_hit = (core_addr_i[`CSFR_IDX_LOW_MSB:0] == `CSFR_IDX_LOW);
      bus_hit = (haddr_i[1:0] == 2'h0)
         && (haddr_i[`CSFR_IDX_LOW_MSB+2:2] == `CSFR_IDX_LOW)
         && (haddr_i[31:11] == 21'h000000);
      bus_take = hsel_i && hready_i && (htrans_i == `CSFR_HTRANS_NONSEQ);
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_r = r;
      wr_any = 1'b0;
      wdat = r.status;
      // Core write has priority over a bus write in the same cycle
      if (core_wr_i && core_hit) begin
         wr_any = 1'b1;
         wdat = core_wr_data_i;
      end else if (r.wr_pend) begin
         wr_any = 1'b1;
         wdat = hwdata_i[7:0];
      end
      if (wr_any) begin
         next_r.status[`CSFR_BIT_IRP:`CSFR_BIT_RPL] =
            wdat[`CSFR_BIT_IRP:`CSFR_BIT_RPL];
         if (alu_op_i == CSFR_ALU_NONE || !(core_wr_i && core_hit)) begin
            next_r.status[`CSFR_BIT_Z:`CSFR_BIT_C] =
               wdat[`CSFR_BIT_Z:`CSFR_BIT_C];
         end
         // Reset-cause bits are never taken from write data
      end
      unique case (alu_op_i)
         CSFR_ALU_ADD, CSFR_ALU_SUB: begin
            next_r.status[`CSFR_BIT_Z] = fu_z;
            next_r.status[`CSFR_BIT_DC] = fu_dc;
            next_r.status[`CSFR_BIT_C] = fu_c;
         end
         CSFR_ALU_LOGIC: begin
            next_r.status[`CSFR_BIT_Z] = fu_z;
         end
         CSFR_ALU_CLEAR: begin
            next_r.status[`CSFR_BIT_Z] = fu_z;
         end
         CSFR_ALU_NONE: begin
         end
         default: begin
         end
      endcase
      if (watchdog_kick_i) begin
         next_r.status[`CSFR_BIT_TO] = 1'b1;
         next_r.status[`CSFR_BIT_PD] = 1'b1;
      end else if (sleep_i) begin
         next_r.status[`CSFR_BIT_TO] = 1'b1;
         next_r.status[`CSFR_BIT_PD] = 1'b0;
      end
      // Timeout wins over kick and sleep in the same cycle
      if (wdt_timeout_i) begin
         next_r.status[`CSFR_BIT_TO] = 1'b0;
      end
      next_r.wr_pend = bus_take && hwrite_i && bus_hit;
      next_r.rd_data = (bus_take && !hwrite_i && bus_hit) ? r.status : 8'h00;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         r.status <= `CSFR_RESET;
         r.wr_pend <= 1'b0;
         r.rd_data <= 8'h00;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_comb begin
      processor_flags_o = r.status;
      // One selects banks two and three for indirect access
      indirect_bank_select_o = r.status[`CSFR_BIT_IRP];
      // Plain two-bit bank number: 00..11 give banks zero..three
      direct_bank_field_o =
         r.status[`CSFR_BIT_RPH:`CSFR_BIT_RPL];
      hrdata_o = {24'h000000, r.rd_data};
      hreadyout_o = 1'b1;
      hresp_o = `CSFR_HRESP_OKAY;
   end
endmodule : csfr_status

// File: sim/csfr_status_props.sv
// Checker of the status register flags and bank outputs.
// Assumes binding to csfr_status, one clock, synchronous reset.
`timescale 1ns/1ps
module csfr_status_chk
   import csfr_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic core_wr_i,
   input wire logic [8:0] core_addr_i,
   input wire csfr_alu_op_t alu_op_i,
   input wire logic [7:0] logic_res_i,
   input wire logic wdt_timeout_i,
   input wire logic watchdog_kick_i,
   input wire logic sleep_i,
   input wire logic [7:0] processor_flags_o,
   input wire logic indirect_bank_select_o,
   input wire logic [1:0] direct_bank_field_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   wire [7:0] pf = processor_flags_o;
   wire st = core_wr_i && core_addr_i[6:0] == 7'h03;
   wire nev = !wdt_timeout_i && !watchdog_kick_i && !sleep_i;
   sequence s_clr;
      st && alu_op_i == CSFR_ALU_CLEAR && nev;
   endsequence
   sequence s_cleared;
      (pf & 8'he4) == 8'h04 && (pf & 8'h1b) == ($past(pf) & 8'h1b);
   endsequence
   chk_clear_op: assert property (s_clr |=> s_cleared)
      else $error("clear op wrong");
   chk_bank_ind: assert property (indirect_bank_select_o == pf[7])
      else $error("indirect bank wrong");
   chk_bank_dir: assert property (direct_bank_field_o == pf[6:5])
      else $error("direct bank wrong");
   chk_flag_hold: assert property (nev |=> pf[4:3] == $past(pf[4:3]))
      else $error("reset flags changed");
   chk_wdt_clear: assert property (wdt_timeout_i |=> !pf[4])
      else $error("timeout not seen");
   chk_kick_set: assert property (watchdog_kick_i && !wdt_timeout_i
      |=> pf[4:3] == 2'b11)
      else $error("kick wrong");
   chk_sleep_flags: assert property (sleep_i && !watchdog_kick_i
      && !wdt_timeout_i |=> pf[4:3] == 2'b10)
      else $error("sleep wrong");
   chk_logic_zero: assert property (st && alu_op_i == CSFR_ALU_LOGIC
      |=> pf[2] == ($past(logic_res_i) == 8'h0))
      else $error("zero flag wrong");
endmodule : csfr_status_chk
bind csfr_status csfr_status_chk chk_u (.*);

// File: sim/csfr_core_model.sv
// Core model: issues one instruction per call of run.
// Assumes the bench owns the sequence of calls.
`timescale 1ns/1ps
module csfr_core_model
   import csfr_pkg::*;
(
   input wire logic clock_i,
   output logic core_wr_i = 0,
   output logic [8:0] core_addr_i = 0,
   output logic [7:0] core_wr_data_i = 0,
   output csfr_alu_op_t alu_op_i = CSFR_ALU_NONE,
   output logic [7:0] alu_a_i = 0,
   output logic [7:0] alu_b_i = 0,
   output logic [7:0] logic_res_i = 0,
   output logic [2:0] ev_o = 0,
   output logic strobe_o = 0
);
   task run(input logic [8:0] ad, input logic [7:0] d,
      input csfr_alu_op_t op, input logic [7:0] a, input logic [7:0] b,
      input logic [2:0] ev);
      @(posedge clock_i);
      core_wr_i <= 1;
      strobe_o <= 1;
      core_addr_i <= ad;
      core_wr_data_i <= d;
      alu_op_i <= op;
      alu_a_i <= a;
      alu_b_i <= b;
      logic_res_i <= a;
      ev_o <= ev;
      @(posedge clock_i);
      core_wr_i <= 0;
      strobe_o <= 0;
      alu_op_i <= CSFR_ALU_NONE;
      ev_o <= 0;
   endtask : run
endmodule : csfr_core_model

// File: sim/tb.sv
// Bench: core model and AHB-Lite master drive the status register.
// Assumes a zero-wait slave and flags one edge after an instruction.
`timescale 1ns/1ps
module tb
   import csfr_pkg::*;
;
   logic clock_i = 0, rst_n_i = 0, hwrite_i = 0, rd_dp = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0;
   logic [1:0] htrans_i = 0;
   logic [7:0] f, d, a, b;
   logic [8:0] s;
   int fails = 0, total_checks = 0, cyc = 0, seed = 32'h319e, i;
   logic [7:0] qf[$];
   logic [31:0] qr[$];
   wire core_wr_i, hreadyout_o, hresp_o, indirect_bank_select_o, strobe_o;
   wire [8:0] core_addr_i;
   wire [7:0] core_wr_data_i, alu_a_i, alu_b_i, logic_res_i, processor_flags_o;
   wire [1:0] direct_bank_field_o;
   wire [31:0] hrdata_o;
   wire [2:0] ev_o;
   wire csfr_alu_op_t alu_op_i;
   wire wdt_timeout_i = ev_o[2], watchdog_kick_i = ev_o[1], sleep_i = ev_o[0];
   wire hsel_i = 1'h1, hready_i = hreadyout_o;
   wire [2:0] hsize_i = 3'h2;
   always #4 clock_i = ~clock_i;
   csfr_status dut_u (.*);
   csfr_core_model core_u (.*);
   task cmp_f(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %0t %h %h", $time, g, e);
      end
   endtask : cmp_f
   task cmp_r(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %0t %h %h", $time, g, e);
      end
   endtask : cmp_r
   task finish_test;
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   task xfer(input logic w, input logic [31:0] ad, input logic [7:0] dt);
      @(posedge clock_i);
      haddr_i <= ad;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      do @(posedge clock_i); while (!hready_i);
      htrans_i <= 2'h0;
      hwdata_i <= {24'h0, dt};
      rd_dp <= !w;
      do @(posedge clock_i); while (!hready_i);
      rd_dp <= 0;
   endtask : xfer
   task ins(input logic [8:0] ad, input logic [7:0] dt, input csfr_alu_op_t op,
      input logic [7:0] x, input logic [7:0] y, input logic [2:0] ev);
      qf.push_back(f);
      core_u.run(ad, dt, op, x, y, ev);
   endtask : ins
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         finish_test();
      end
      if (rd_dp) cmp_r(hrdata_o, qr.pop_front());
      if (strobe_o) begin
         @(negedge clock_i);
         cmp_f(processor_flags_o, qf.pop_front());
      end
   end
   initial begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1;
      f = 8'h18;
      xfer(1, 32'h010, 8'hff);
      for (i = 0; i < 5; i++) begin
         qr.push_back(i < 4 ? {24'h0, f} : 32'h0);
         xfer(0, i < 4 ? 32'h00c + (i << 9) : 32'h010, 0);
      end
      for (i = 0; i < 4; i++) begin
         d = $random(seed);
         d[6:5] = i[1:0];
         d[7] = i[0];
         xfer(1, 32'h00c + (i << 9), d);
         f = {d[7:5], f[4:3], d[2:0]};
         qr.push_back({24'h0, f});
         xfer(0, 32'h60c - (i << 9), 0);
      end
      for (i = 0; i < 4; i++) begin
         d = $random(seed);
         f = {d[7:5], f[4:3], d[2:0]};
         ins({i[1:0], 7'h03}, d, CSFR_ALU_NONE, 0, 0, 0);
      end
      f = {3'h0, f[4:3], 1'h1, f[1:0]};
      ins(9'h003, 0, CSFR_ALU_CLEAR, 0, 0, 0);
      for (i = 0; i < 12; i++) begin
         d = $random(seed);
         a = i < 2 ? 8'h88 : $random(seed);
         b = i < 2 ? 8'h88 : $random(seed);
         s = i[0] ? a - b : a + b;
         f = {d[7:5], f[4:3], s[7:0] == 0,
            i[0] ? a[3:0] >= b[3:0] : a[3:0] + b[3:0] > 15,
            i[0] ? a >= b : s[8]};
         ins(9'h003, d, i[0] ? CSFR_ALU_SUB : CSFR_ALU_ADD, a, b, 0);
      end
      for (i = 0; i < 2; i++) begin
         d = $random(seed);
         f = {d[7:5], f[4:3], i == 0, f[1:0]};
         ins(9'h003, d, CSFR_ALU_LOGIC, 8'(i * 5), 0, 0);
      end
      f[4:3] = 2'h1;
      ins(9'h004, 8'hff, CSFR_ALU_NONE, 0, 0, 3'h4);
      f[4:3] = 2'h2;
      ins(9'h004, 8'hff, CSFR_ALU_NONE, 0, 0, 3'h1);
      f[4:3] = 2'h3;
      ins(9'h004, 8'hff, CSFR_ALU_NONE, 0, 0, 3'h2);
      f[4:3] = 2'h1;
      ins(9'h004, 8'hff, CSFR_ALU_NONE, 0, 0, 3'h6);
      rst_n_i <= 0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1;
      qr.push_back(32'h18);
      xfer(0, 32'h20c, 0);
      finish_test();
   end
endmodule : tb
